// *** verilog/scg_top.sv ***
// Operation
// - Fastest instruction takes two CPU clocks; instruction strobe every second CPU tick.
// - CPU clock is main divided by 1,2,4,8,16 or subsystem clock divided by 2.
// - Mode register bit 0 picks oscillator direct or through half scaler.
// - Mode register is written only as a whole byte.
// - Reset clears the mode register, selecting the scaled path.
// - Any mode register write stretches main clock up to two oscillator periods.
// - Mode change switches peripheral clocks as well as CPU clock.
// - Scaler divides main clock into the derived clock set.
// - Control bit 6 set disconnects subsystem feedback resistor.
// - Reset loads control register 04h and mode register 00h.
// - Main oscillator stays stopped while reset is held.
// - On main clock both STOP and HALT standby are available.
// - On subsystem clock only HALT works; subsystem oscillator never stops.
// - Subsystem clock feeds the CPU and its timers; other peripherals stop with main clock.
// - Stop bit halts main oscillator only once subsystem clock is active.
// - With main clock active the divider field sets instruction time.
// - Main clock equals oscillator when bypass is one, else half.
// - Feedback bit zero keeps the resistor connected, one disconnects it.
`timescale 1ns/10ps
`default_nettype none
module scg_top
  import scg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sub_clk_pin_i,
  input wire logic stop_req_i,
  input wire logic halt_req_i,
  input wire logic wake_i,
  output logic cpu_clk_en_o,
  output logic instr_en_o,
  output logic periph_clk_en_o,
  output logic [NUM_DIV-1:0] periph_div_en_o,
  output logic sub_clk_en_o,
  output logic main_osc_run_o,
  output logic feedback_res_on_o,
  output logic clock_source_status_o,
  output logic halt_o,
  output logic stop_o
);

  // Bus slave
  logic ack_r;
  logic [31:0] dat_r;
  logic bus_req;
  logic wr_commit;
  logic wr_pcc;
  logic wr_oscillation_mode_sel;

  // Control fields
  logic main_osc_stop_bit_r;
  logic feedback_disable_bit_r;
  logic clock_source_select_r;
  logic [DIV_W-1:0] cpu_clock_divider_field_r;
  logic [DIV_W-1:0] div_nxt;
  logic scaler_bypass_bit_r;

  // Oscillator model and main clock
  logic [3:0] fx_cnt_r;
  logic fx_tick;
  logic osc_run;
  logic half_r;
  logic [1:0] stretch_r;
  logic fxx_tick;

  // Subsystem clock pin
  logic sub_s1_r;
  logic sub_s2_r;
  logic sub_s3_r;
  logic sub_edge;
  logic sub_half_r;
  logic sub_cpu_tick;

  // CPU clock
  logic [NUM_DIV-1:0] div_en;
  logic cpu_tick;
  logic clock_source_status;
  logic [1:0] instr_cnt_r;

  scg_pwr_t pwr_r;

  assign bus_req = wb_cyc_i & wb_stb_i;
  // Write lands on the edge where the master sees ack
  assign wr_commit = bus_req & wb_we_i & ack_r;
  // Byte lane 0 must be enabled; partial-byte writes do not exist here
  assign wr_pcc = wr_commit & (wb_adr_i == ADDR_PCC) & wb_sel_i[0];
  assign wr_oscillation_mode_sel = wr_commit & (wb_adr_i == ADDR_OSCILLATION_MODE_SEL) & wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req & ~ack_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0000_0000;
    end else if (bus_req && !ack_r) begin
      case (wb_adr_i)
        ADDR_PCC: begin
          dat_r <= {24'h00_0000, main_osc_stop_bit_r, feedback_disable_bit_r, clock_source_status,
                    clock_source_select_r, 1'b0, cpu_clock_divider_field_r};
        end
        ADDR_OSCILLATION_MODE_SEL: begin
          dat_r <= {31'h0000_0000, scaler_bypass_bit_r};
        end
        ADDR_STAT: begin
          dat_r <= {29'h0000_0000, pwr_r == PWR_STOP, pwr_r == PWR_HALT, osc_run};
        end
        default: begin
          dat_r <= 32'h0000_0000;
        end
      endcase
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // Prohibited divider codes leave the field unchanged
  assign div_nxt = (wb_dat_i[PCC_DIV_LSB +: DIV_W] <= DIV_MAX) ?
                   wb_dat_i[PCC_DIV_LSB +: DIV_W] : cpu_clock_divider_field_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_osc_stop_bit_r <= PCC_RST[PCC_MCC_BIT];
      feedback_disable_bit_r <= PCC_RST[PCC_FRC_BIT];
      clock_source_select_r <= PCC_RST[PCC_CSS_BIT];
      cpu_clock_divider_field_r <= PCC_RST[PCC_DIV_LSB +: DIV_W];
    end else if (wr_pcc) begin
      main_osc_stop_bit_r <= wb_dat_i[PCC_MCC_BIT];
      feedback_disable_bit_r <= wb_dat_i[PCC_FRC_BIT];
      clock_source_select_r <= wb_dat_i[PCC_CSS_BIT];
      cpu_clock_divider_field_r <= div_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scaler_bypass_bit_r <= OSCILLATION_MODE_SEL_RST[OSCILLATION_MODE_SEL_MCS_BIT];
    end else if (wr_oscillation_mode_sel) begin
      scaler_bypass_bit_r <= wb_dat_i[OSCILLATION_MODE_SEL_MCS_BIT];
    end
  end

  // Software owns the resistor setting;
  // hardware only reflects the bit
  assign feedback_res_on_o = ~feedback_disable_bit_r;

  // Oscillator stops in STOP standby, or on the stop bit once the CPU
  // is on the subsystem clock; reset holds it too.
  // An external main clock cannot honour this, so software must avoid it
  assign osc_run = ~rst_i & (pwr_r != PWR_STOP)
                   & ~(main_osc_stop_bit_r & clock_source_status);

  always_ff @(posedge clk_i) begin
    if (rst_i || !osc_run) begin
      fx_cnt_r <= 4'h0;
    end else if (fx_cnt_r == OSC_DIV - 4'h1) begin
      fx_cnt_r <= 4'h0;
    end else begin
      fx_cnt_r <= fx_cnt_r + 4'h1;
    end
  end

  assign fx_tick = osc_run & (fx_cnt_r == OSC_DIV - 4'h1);

  // A mode write restarts the half scaler and drops up to two
  // oscillator periods; timers on the main clock see one long count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stretch_r <= 2'h0;
    end else if (wr_oscillation_mode_sel) begin
      stretch_r <= STRETCH_TICKS;
    end else if (fx_tick && stretch_r != 2'h0) begin
      stretch_r <= stretch_r - 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || wr_oscillation_mode_sel) begin
      half_r <= 1'b0;
    end else if (fx_tick && stretch_r == 2'h0) begin
      half_r <= ~half_r;
    end
  end

  // Same main clock feeds scaler, CPU and peripherals
  assign fxx_tick = fx_tick & (stretch_r == 2'h0)
                    & (scaler_bypass_bit_r | half_r);

  scg_prescaler u_prescaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .fxx_en_i(fxx_tick),
    .div_en_o(div_en)
  );

  // Peripherals other than the subsystem timers run from the main clock
  // only, so they stall whenever it stops
  assign periph_clk_en_o = fxx_tick;
  assign periph_div_en_o = div_en;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sub_s1_r <= 1'b0;
      sub_s2_r <= 1'b0;
      sub_s3_r <= 1'b0;
    end else begin
      sub_s1_r <= sub_clk_pin_i;
      sub_s2_r <= sub_s1_r;
      sub_s3_r <= sub_s2_r;
    end
  end

  // Subsystem clock has no stop path at all
  assign sub_edge = sub_s2_r & ~sub_s3_r;
  assign sub_clk_en_o = sub_edge;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sub_half_r <= 1'b0;
    end else if (sub_edge) begin
      sub_half_r <= ~sub_half_r;
    end
  end

  // CPU runs at half the subsystem rate when it selects that source
  assign sub_cpu_tick = sub_edge & sub_half_r;

  scg_clk_switch u_switch (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .main_tick_i(div_en),
    .sub_tick_i(sub_cpu_tick),
    .css_i(clock_source_select_r),
    .div_i(cpu_clock_divider_field_r),
    .cpu_tick_o(cpu_tick),
    .cls_o(clock_source_status)
  );

  assign clock_source_status_o = clock_source_status;

  // STOP is honoured only on the main clock; HALT in either case
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_r <= PWR_RUN;
    end else begin
      case (pwr_r)
        PWR_RUN: begin
          if (stop_req_i && !clock_source_status) begin
            pwr_r <= PWR_STOP;
          end else if (halt_req_i) begin
            pwr_r <= PWR_HALT;
          end
        end
        PWR_HALT: begin
          if (wake_i) begin
            pwr_r <= PWR_RUN;
          end
        end
        PWR_STOP: begin
          if (wake_i) begin
            pwr_r <= PWR_RUN;
          end
        end
        default: begin
          pwr_r <= PWR_RUN;
        end
      endcase
    end
  end

  assign halt_o = (pwr_r == PWR_HALT);
  assign stop_o = (pwr_r == PWR_STOP);
  assign main_osc_run_o = osc_run;

  assign cpu_clk_en_o = cpu_tick & (pwr_r == PWR_RUN);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      instr_cnt_r <= 2'h0;
    end else if (cpu_clk_en_o) begin
      instr_cnt_r <= (instr_cnt_r == INSTR_CLKS - 2'h1) ? 2'h0 : instr_cnt_r + 2'h1;
    end
  end

  assign instr_en_o = cpu_clk_en_o & (instr_cnt_r == INSTR_CLKS - 2'h1);

endmodule
`default_nettype wire

// *** pkg/scg_pkg.sv ***
package scg_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned OSC_HZ = 5_000_000;
  // One main oscillator period in system clocks
  localparam logic [3:0] OSC_DIV = 4'(CLK_HZ / OSC_HZ);

  localparam logic [3:0] ADDR_PCC = 4'h0;
  localparam logic [3:0] ADDR_OSCILLATION_MODE_SEL = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;

  localparam logic [7:0] PCC_RST = 8'h04;
  localparam logic [7:0] OSCILLATION_MODE_SEL_RST = 8'h00;

  localparam int PCC_MCC_BIT = 7;
  localparam int PCC_FRC_BIT = 6;
  localparam int PCC_CLS_BIT = 5;
  localparam int PCC_CSS_BIT = 4;
  localparam int PCC_DIV_LSB = 0;
  localparam int DIV_W = 3;
  localparam logic [2:0] DIV_MAX = 3'h4;
  localparam int OSCILLATION_MODE_SEL_MCS_BIT = 0;

  localparam int STAT_OSC_BIT = 0;
  localparam int STAT_HALT_BIT = 1;
  localparam int STAT_STOP_BIT = 2;

  // Oscillator periods lost on any mode write
  localparam logic [1:0] STRETCH_TICKS = 2'h2;
  // CPU clocks per fastest instruction
  localparam logic [1:0] INSTR_CLKS = 2'h2;
  localparam int NUM_DIV = 5;

  typedef enum logic [2:0] {
    PWR_RUN = 3'b001,
    PWR_HALT = 3'b010,
    PWR_STOP = 3'b100
  } scg_pwr_t;

endpackage

// *** verilog/scg_prescaler.sv ***
`timescale 1ns/10ps
`default_nettype none
module scg_prescaler
  import scg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fxx_en_i,
  output logic [NUM_DIV-1:0] div_en_o
);

  logic [NUM_DIV-2:0] cnt_r;

  function automatic logic low_ones(input logic [NUM_DIV-2:0] c, input int k);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < NUM_DIV - 1; i++) begin
      if (i < k && !c[i]) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else if (fxx_en_i) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Tap k ticks once every 2^k main clocks
  always_comb begin
    for (int k = 0; k < NUM_DIV; k++) begin
      div_en_o[k] = fxx_en_i & low_ones(cnt_r, k);
    end
  end

endmodule
`default_nettype wire

// *** verilog/scg_clk_switch.sv ***
`timescale 1ns/10ps
`default_nettype none
module scg_clk_switch
  import scg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [NUM_DIV-1:0] main_tick_i,
  input wire logic sub_tick_i,
  input wire logic css_i,
  input wire logic [DIV_W-1:0] div_i,
  output logic cpu_tick_o,
  output logic cls_o
);

  logic act_css_r;
  logic [DIV_W-1:0] act_div_r;
  logic pend_r;
  logic cur_tick;
  logic changed;

  assign cur_tick = act_css_r ? sub_tick_i : main_tick_i[act_div_r];
  assign changed = (css_i != act_css_r) || (div_i != act_div_r);

  // Settings move only on an old-clock tick; first new tick is swallowed
  // so no period is shorter than the new one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_css_r <= PCC_RST[PCC_CSS_BIT];
      act_div_r <= PCC_RST[PCC_DIV_LSB +: DIV_W];
      pend_r <= 1'b0;
    end else if (cur_tick && pend_r) begin
      pend_r <= 1'b0;
    end else if (cur_tick && changed) begin
      act_css_r <= css_i;
      act_div_r <= div_i;
      pend_r <= 1'b1;
    end
  end

  assign cpu_tick_o = cur_tick & ~pend_r;
  assign cls_o = act_css_r;

endmodule
`default_nettype wire

// *** testbench/scg_top_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module scg_top_asserts
  import scg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic sub_clk_pin_i,
  input wire logic stop_req_i,
  input wire logic halt_req_i,
  input wire logic wake_i,
  input wire logic cpu_clk_en_o,
  input wire logic instr_en_o,
  input wire logic periph_clk_en_o,
  input wire logic [NUM_DIV-1:0] periph_div_en_o,
  input wire logic sub_clk_en_o,
  input wire logic main_osc_run_o,
  input wire logic feedback_res_on_o,
  input wire logic clock_source_status_o,
  input wire logic halt_o,
  input wire logic stop_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Fastest tick source is one oscillator period, ten clocks
  sequence s_idle8(e);
    (!e) [*8];
  endsequence
  AST_ACK_PULSE: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single cycle");
  AST_FB_WRITE: assert property (wb_ack_o && wb_we_i && wb_cyc_i && wb_stb_i &&
    wb_sel_i[0] && wb_adr_i == ADDR_PCC |=> feedback_res_on_o == !$past(wb_dat_i[6]))
    else $error("feedback resistor does not follow control bit");
  AST_RST_QUIET: assert property ($past(rst_i) |-> !cpu_clk_en_o && !periph_clk_en_o)
    else $error("tick right after reset release");
  AST_OSC_RUN: assert property (!$past(rst_i, 2) && !$past(stop_o) && !stop_o &&
    !$past(clock_source_status_o) && !clock_source_status_o |-> main_osc_run_o)
    else $error("main oscillator stopped while on main clock");
  AST_STOP_MAIN: assert property ($rose(stop_o) |-> !$past(clock_source_status_o))
    else $error("stop entered on subsystem clock");
  AST_STOP_REQ: assert property (stop_req_i && !clock_source_status_o && !halt_o &&
    !stop_o && !wake_i && !halt_req_i |=> stop_o)
    else $error("stop request on main clock ignored");
  AST_CPU_RUN: assert property (cpu_clk_en_o |-> !halt_o && !stop_o)
    else $error("cpu tick in standby");
  AST_INSTR: assert property (instr_en_o |-> cpu_clk_en_o)
    else $error("instruction strobe without cpu tick");
  AST_DIV: assert property (|periph_div_en_o |-> periph_clk_en_o)
    else $error("divided tick off the main clock");
  AST_FXX_GAP: assert property (periph_clk_en_o |=> s_idle8(periph_clk_en_o))
    else $error("main clock period too short");
  AST_CPU_GAP: assert property (cpu_clk_en_o |=> s_idle8(cpu_clk_en_o))
    else $error("shortened cpu clock");
endmodule
bind scg_top scg_top_asserts u_chk (.*);
`default_nettype wire

// *** testbench/scg_top_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module scg_top_tb
  import scg_pkg::*;
;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic sub_clk_pin_i = 0, stop_req_i = 0, halt_req_i = 0, wake_i = 0;
  logic wb_ack_o, cpu_clk_en_o, instr_en_o, periph_clk_en_o, sub_clk_en_o;
  logic main_osc_run_o, feedback_res_on_o, clock_source_status_o, halt_o, stop_o;
  logic [NUM_DIV-1:0] periph_div_en_o;
  int mismatches = 0, comparisons = 0, seed = 30132, n, r;
  wire [3:0] ev = {sub_clk_en_o, periph_clk_en_o, instr_en_o, cpu_clk_en_o};
  scg_top DUT (.*);
  always #10 clk_i = ~clk_i;
  // Half period of 763 clocks keeps the pin edges off the sampling edge
  always #15260 sub_clk_pin_i = ~sub_clk_pin_i;
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk("osc_rst", main_osc_run_o, 0);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [3:0] s, input logic [7:0] d);
    int t;
    t = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    if (t >= 50) begin
      mismatches++;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Clocks from one event of the chosen tick to the next
  task automatic gap(input int k, output int g);
    int t;
    t = 0;
    g = 0;
    @(posedge clk_i);
    while (ev[k] !== 1'b1 && t < 9000) begin
      @(posedge clk_i);
      t++;
    end
    do begin
      @(posedge clk_i);
      g++;
    end while (ev[k] !== 1'b1 && g < 9000);
  endtask
  task automatic pulse(input int k);
    {wake_i, halt_req_i, stop_req_i} <= 3'(1 << k);
    @(posedge clk_i);
    {wake_i, halt_req_i, stop_req_i} <= 3'h0;
    repeat (3) @(posedge clk_i);
  endtask
  initial begin
    #2_000_000;
    mismatches++;
    test_done();
  end
  initial begin
    do_reset();
    wb(0, ADDR_PCC, 4'hf, 8'h00);
    chk("ctrl_rst", q, {24'h0, PCC_RST});
    wb(0, ADDR_OSCILLATION_MODE_SEL, 4'hf, 8'h00);
    chk("mode_rst", q, {24'h0, OSCILLATION_MODE_SEL_RST});
    chk("fb_rst", feedback_res_on_o, 1);
    wb(1, ADDR_OSCILLATION_MODE_SEL, 4'h1, 8'h01);
    do_reset();
    wb(0, ADDR_OSCILLATION_MODE_SEL, 4'hf, 8'h00);
    chk("mode_clr", q, 0);
    for (int m = 0; m < 2; m++) begin
      // Mode is set only right after reset, before peripherals count
      do_reset();
      wb(1, ADDR_OSCILLATION_MODE_SEL, 4'h1, {7'h0, m[0]});
      for (int d = 0; d < 5; d++) begin
        r = $random(seed);
        wb(1, ADDR_PCC, 4'h1, {1'b0, r[6], r[5], 1'b0, r[3], d[2:0]});
        wb(0, ADDR_PCC, 4'hf, 8'h00);
        chk("ctrl_rd", q, {25'h0, r[6], 3'h0, d[2:0]});
        chk("fb", feedback_res_on_o, !r[6]);
        repeat (3) gap(0, n);
        chk("cpu_gap", n, (20 - 10 * m) << d);
        gap(1, n);
        chk("instr_gap", n, (40 - 20 * m) << d);
        gap(2, n);
        chk("fxx_gap", n, 20 - 10 * m);
      end
    end
    r = $random(seed);
    wb(1, ADDR_PCC, 4'h1, {5'h0, 3'h5 | {1'b0, r[1], 1'b0}});
    wb(0, ADDR_PCC, 4'hf, 8'h00);
    chk("div_bad", q[2:0], 3'h4);
    wb(1, ADDR_OSCILLATION_MODE_SEL, 4'he, 8'h00);
    wb(0, ADDR_OSCILLATION_MODE_SEL, 4'hf, 8'h00);
    chk("mode_lane", q, 1);
    wb(0, 4'hc, 4'hf, 8'h00);
    chk("unmapped", q, 0);
    pulse(1);
    chk("halt", halt_o, 1);
    gap(2, n);
    chk("halt_fxx", n, 10);
    pulse(2);
    pulse(0);
    chk("stop", stop_o, 1);
    chk("stop_osc", main_osc_run_o, 0);
    gap(3, n);
    chk("stop_sub", n, 1526);
    pulse(2);
    wb(1, ADDR_PCC, 4'h1, 8'h80);
    repeat (100) @(posedge clk_i);
    chk("mcc_main", main_osc_run_o, 1);
    wb(1, ADDR_PCC, 4'h1, 8'h90);
    for (int t = 0; t < 20000 && clock_source_status_o !== 1'b1; t++) begin
      @(posedge clk_i);
    end
    repeat (5) @(posedge clk_i);
    chk("cls", clock_source_status_o, 1);
    chk("osc_off", main_osc_run_o, 0);
    repeat (2) gap(0, n);
    chk("sub_gap", n, 3052);
    pulse(0);
    chk("no_stop", stop_o, 0);
    pulse(1);
    chk("sub_halt", halt_o, 1);
    pulse(2);
    test_done();
  end
endmodule
`default_nettype wire
